// ---- include/bsc_pkg.sv ----
// shared constants and types of the boundary-scan port and its controller
package bsc_pkg;

  // ==========================================================================
  // boundary register lengths per variant
  localparam int BND_LEN_SMALL = 522;
  localparam int BND_LEN_MID   = 621;
  localparam int BND_LEN_LARGE = 666;
  localparam int BND_LEN_DEF   = BND_LEN_LARGE;

  // ==========================================================================
  // instruction register
  localparam int         IR_LEN     = 3;
  localparam logic [2:0] IR_CAPT    = 3'h1;
  localparam logic [2:0] OP_EXTEST  = 3'h0;
  localparam logic [2:0] OP_SAMPLE  = 3'h5;
  localparam logic [2:0] OP_BYPASS  = 3'h7;

  // ==========================================================================
  // tap controller states
  typedef enum logic [3:0] {
    TS_RESET   = 4'hf,
    TS_IDLE    = 4'hc,
    TS_SEL_DR  = 4'h7,
    TS_CAP_DR  = 4'h6,
    TS_SH_DR   = 4'h2,
    TS_EX1_DR  = 4'h1,
    TS_PAU_DR  = 4'h3,
    TS_EX2_DR  = 4'h0,
    TS_UPD_DR  = 4'h5,
    TS_SEL_IR  = 4'h4,
    TS_CAP_IR  = 4'he,
    TS_SH_IR   = 4'ha,
    TS_EX1_IR  = 4'h9,
    TS_PAU_IR  = 4'hb,
    TS_EX2_IR  = 4'h8,
    TS_UPD_IR  = 4'hd
  } bsc_tap_state_t;

  // ==========================================================================
  // controller commands and sequences
  typedef enum logic [1:0] {
    CMD_RESET = 2'h0,
    CMD_IR    = 2'h1,
    CMD_DR    = 2'h2
  } bsc_cmd_t;

  localparam int RESET_TMS_ONES = 5;
  localparam int RESET_SEQ_LEN  = 6;
  localparam int HDR_LEN_IR     = 4;
  localparam int HDR_LEN_DR     = 3;
  localparam int HDR_TMS_TAIL   = 2;
  localparam int POST_LEN       = 2;

  // ==========================================================================
  // link timing
  localparam int REF_PERIOD_NS    = 50;
  localparam int TCK_HIGH_MIN_NS  = 50;
  localparam int TCK_LOW_MIN_NS   = 50;
  localparam int TCK_HALF_MIN_CYC =
    (TCK_HIGH_MIN_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int SYNC_MARGIN_CYC  = 3;
  localparam int TCK_HALF_CYC_DEF =
    (TCK_HALF_MIN_CYC > SYNC_MARGIN_CYC) ? TCK_HALF_MIN_CYC
                                         : SYNC_MARGIN_CYC + 1;

endpackage : bsc_pkg

// ---- include/bsc_tap_if.sv ----
// link wires between test controller and scanned device
`timescale 1ns/1ps
interface bsc_tap_if;
  logic tck;
  logic tms_o;
  logic tms_oe;
  logic tdi_o;
  logic tdi_oe;
  logic tdo_o;
  logic tdo_oe;
  logic tms;
  logic tdi;
  logic tdo;

  // ==========================================================================
  // wire levels with weak pull-ups on undriven pins
  assign tms = tms_oe ? tms_o : 1'b1; // RQ8
  assign tdi = tdi_oe ? tdi_o : 1'b1; // RQ8
  assign tdo = tdo_oe ? tdo_o : 1'b1;

  modport ctl (output tck, output tms_o, output tms_oe, output tdi_o,
               output tdi_oe, input tdo);
  modport dev (input tck, input tms, input tdi, output tdo_o,
               output tdo_oe);
endinterface : bsc_tap_if

// ---- rtl/bsc_tap_ctl.sv ----
// test controller end: divides ref_clk into tck and runs scans
`timescale 1ns/1ps
module bsc_tap_ctl #(
  parameter int BND_LEN  = bsc_pkg::BND_LEN_DEF,
  parameter int HALF_CYC = bsc_pkg::TCK_HALF_CYC_DEF,
  parameter int LEN_W    = $clog2(BND_LEN + 1)
) (
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  bsc_tap_if.ctl                    link,
  input  wire logic                 cmd_valid,
  output logic                      cmd_ready,
  input  wire bsc_pkg::bsc_cmd_t    cmd_op,
  input  wire logic [LEN_W-1:0]     cmd_len,
  input  wire logic [BND_LEN-1:0]   cmd_data,
  output logic                      rsp_valid,
  output logic [BND_LEN-1:0]        rsp_data
);
  localparam int DIV_W = $clog2(HALF_CYC + 1);
  localparam int CNT_W = $clog2(BND_LEN + 16);

  typedef enum logic [1:0] {
    CS_IDLE = 2'h0,
    CS_LOAD = 2'h1,
    CS_LOW  = 2'h2,
    CS_HIGH = 2'h3
  } bsc_ctl_state_t;

  bsc_ctl_state_t      state_ff;
  bsc_pkg::bsc_cmd_t   op_ff;
  logic [LEN_W-1:0]    len_ff;
  logic [BND_LEN-1:0]  data_ff;
  logic [CNT_W-1:0]    cnt_ff;
  logic [LEN_W-1:0]    sidx_ff;
  logic [DIV_W-1:0]    div_ff;
  logic                tck_ff;
  logic                tms_ff;
  logic                tdi_ff;
  logic                oe_ff;
  logic                tdo_meta_ff;
  logic                tdo_sync_ff;
  logic                rsp_valid_ff;
  logic [BND_LEN-1:0]  rsp_ff;
  logic                half_done;
  logic                last_bit;
  logic [CNT_W-1:0]    nxt_cnt;
  logic [LEN_W-1:0]    nxt_sidx;

  // ==========================================================================
  // sequence helpers
  function automatic int hdr_of(bsc_pkg::bsc_cmd_t op);
    hdr_of = (op == bsc_pkg::CMD_IR) ? bsc_pkg::HDR_LEN_IR
                                     : bsc_pkg::HDR_LEN_DR;
  endfunction : hdr_of

  function automatic logic in_shift(int i);
    in_shift = (op_ff != bsc_pkg::CMD_RESET) && (i >= hdr_of(op_ff))
               && (i < hdr_of(op_ff) + int'(len_ff));
  endfunction : in_shift

  // tms walks idle -> select -> capture -> shift -> exit1 -> update -> idle
  function automatic logic tms_of(int i);
    int h;
    int e;
    h = hdr_of(op_ff);
    e = h + int'(len_ff);
    if (op_ff == bsc_pkg::CMD_RESET) tms_of = i < bsc_pkg::RESET_TMS_ONES;
    else if (i < h) tms_of = i < h - bsc_pkg::HDR_TMS_TAIL;
    else if (i < e) tms_of = (i == e - 1);
    else tms_of = (i == e);
  endfunction : tms_of

  assign half_done = div_ff == DIV_W'(HALF_CYC - 1);
  assign last_bit  = (op_ff == bsc_pkg::CMD_RESET)
    ? (int'(cnt_ff) == bsc_pkg::RESET_SEQ_LEN - 1)
    : (int'(cnt_ff) == hdr_of(op_ff) + int'(len_ff)
                       + bsc_pkg::POST_LEN - 1);
  assign nxt_cnt   = cnt_ff + CNT_W'(1);
  assign nxt_sidx  = sidx_ff + LEN_W'(in_shift(int'(cnt_ff)));

  // ==========================================================================
  // tdo synchroniser
  always_ff @(posedge ref_clk) begin
    tdo_meta_ff <= link.tdo;
    tdo_sync_ff <= tdo_meta_ff;
  end

  // ==========================================================================
  // sequencer
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_ff <= CS_IDLE;
      op_ff    <= bsc_pkg::CMD_RESET;
      len_ff   <= '0;
      data_ff  <= '0;
      cnt_ff   <= '0;
      sidx_ff  <= '0;
      div_ff   <= '0;
    end else begin
      case (state_ff)
        CS_IDLE: begin
          if (cmd_valid) begin
            op_ff    <= cmd_op;
            len_ff   <= cmd_len; // RQ6 RQ7
            data_ff  <= cmd_data;
            cnt_ff   <= '0;
            sidx_ff  <= '0;
            state_ff <= CS_LOAD;
          end
        end
        CS_LOAD: begin
          div_ff   <= '0;
          state_ff <= CS_LOW;
        end
        CS_LOW: begin
          div_ff <= half_done ? '0 : div_ff + DIV_W'(1);
          if (half_done) state_ff <= CS_HIGH;
        end
        CS_HIGH: begin
          div_ff <= half_done ? '0 : div_ff + DIV_W'(1);
          if (half_done) begin
            cnt_ff   <= nxt_cnt;
            sidx_ff  <= nxt_sidx;
            state_ff <= last_bit ? CS_IDLE : CS_LOW;
          end
        end
        default: state_ff <= CS_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // link pins: tms and tdi driven only while a command runs, tck always driven
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tck_ff <= 1'b0;
      tms_ff <= 1'b1;
      tdi_ff <= 1'b0;
      oe_ff  <= 1'b0;
    end else if (state_ff == CS_LOAD) begin
      oe_ff  <= 1'b1;
      tms_ff <= tms_of(0); // RQ1
      tdi_ff <= 1'b0;
    end else if (state_ff == CS_LOW && half_done) begin
      tck_ff <= 1'b1;
    end else if (state_ff == CS_HIGH && half_done) begin
      tck_ff <= 1'b0;
      oe_ff  <= !last_bit;
      tms_ff <= tms_of(int'(nxt_cnt)); // RQ1
      tdi_ff <= in_shift(int'(nxt_cnt)) ? data_ff[nxt_sidx] : 1'b0;
    end
  end

  // ==========================================================================
  // tdo capture at rising tck and answer
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rsp_ff       <= '0;
      rsp_valid_ff <= 1'b0;
    end else begin
      rsp_valid_ff <= state_ff == CS_HIGH && half_done && last_bit;
      if (state_ff == CS_IDLE && cmd_valid) rsp_ff <= '0;
      else if (state_ff == CS_LOW && half_done && in_shift(int'(cnt_ff)))
        rsp_ff[sidx_ff] <= tdo_sync_ff;
    end
  end

  assign link.tck    = tck_ff;
  assign link.tms_o  = tms_ff;
  assign link.tms_oe = oe_ff;
  assign link.tdi_o  = tdi_ff;
  assign link.tdi_oe = oe_ff;
  assign cmd_ready   = state_ff == CS_IDLE;
  assign rsp_valid   = rsp_valid_ff;
  assign rsp_data    = rsp_ff;
endmodule : bsc_tap_ctl

// ---- rtl/bsc_tap_dev.sv ----
// scanned device end: tap state machine, instruction and data registers
// Functional notes
// (RQ1) tap follows the standard state machine
// (RQ2) no scan while configuration is running
// (RQ3) sample captures pins, preload holds pattern
// (RQ4) extest drives update cells, captures input pins
// (RQ5) bypass puts one bit between tdi, tdo
// (RQ6) instruction register is three bits
// (RQ7) boundary length is a per-variant parameter
// (RQ8) tap inputs read high when undriven
// (RQ9) outputs stay undriven during power-up
// (RQ10) unassigned opcodes decode as bypass, all ones
// (RQ11) bypass cell captures zero
`timescale 1ns/1ps
module bsc_tap_dev #(
  parameter int BND_LEN = bsc_pkg::BND_LEN_DEF
) (
  bsc_tap_if.dev                      link,
  input  wire logic                   sys_rst,
  input  wire logic                   config_busy,
  input  wire logic                   power_ok,
  input  wire logic [BND_LEN-1:0]     pin_in,
  input  wire logic [BND_LEN-1:0]     core_out,
  input  wire logic [BND_LEN-1:0]     core_oe,
  output logic [BND_LEN-1:0]          pin_out,
  output logic [BND_LEN-1:0]          pin_oe,
  output logic                        scan_blocked,
  output logic [bsc_pkg::IR_LEN-1:0]  ir_active
);
  bsc_pkg::bsc_tap_state_t       state_ff;
  bsc_pkg::bsc_tap_state_t       nxt_state;
  logic                          rst_meta_ff;
  logic                          rst_sync_ff;
  logic                          cfg_meta_ff;
  logic                          cfg_sync_ff;
  logic [BND_LEN-1:0]            pin_meta_ff;
  logic [BND_LEN-1:0]            pin_sync_ff;
  logic [bsc_pkg::IR_LEN-1:0]    ir_shift_ff;
  logic [bsc_pkg::IR_LEN-1:0]    ir_ff;
  logic                          byp_ff;
  logic [BND_LEN-1:0]            bnd_shift_ff;
  logic [BND_LEN-1:0]            bnd_upd_ff;
  logic                          tdo_ff;
  logic                          tdo_oe_ff;
  logic                          tap_rst;
  logic                          sel_extest;
  logic                          sel_sample;
  logic                          sel_bnd;
  logic                          sel_byp;
  logic                          tms;
  logic                          tdi;

  assign tms = link.tms; // RQ8
  assign tdi = link.tdi; // RQ8

  // ==========================================================================
  // synchronisers into the tck domain
  always_ff @(posedge link.tck) begin
    rst_meta_ff <= sys_rst;
    rst_sync_ff <= rst_meta_ff;
  end

  always_ff @(posedge link.tck) begin
    cfg_meta_ff <= config_busy;
    cfg_sync_ff <= cfg_meta_ff;
  end

  always_ff @(posedge link.tck) begin
    pin_meta_ff <= pin_in;
    pin_sync_ff <= pin_meta_ff;
  end

  // scan held in reset while configuration runs
  assign tap_rst = rst_sync_ff || cfg_sync_ff; // RQ2

  // ==========================================================================
  // tap state machine
  always_ff @(posedge link.tck) begin
    if (tap_rst) begin
      state_ff <= bsc_pkg::TS_RESET; // RQ2
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff) // RQ1
      bsc_pkg::TS_RESET:
        nxt_state = tms ? bsc_pkg::TS_RESET : bsc_pkg::TS_IDLE;
      bsc_pkg::TS_IDLE:
        nxt_state = tms ? bsc_pkg::TS_SEL_DR : bsc_pkg::TS_IDLE;
      bsc_pkg::TS_SEL_DR:
        nxt_state = tms ? bsc_pkg::TS_SEL_IR : bsc_pkg::TS_CAP_DR;
      bsc_pkg::TS_CAP_DR:
        nxt_state = tms ? bsc_pkg::TS_EX1_DR : bsc_pkg::TS_SH_DR;
      bsc_pkg::TS_SH_DR:
        nxt_state = tms ? bsc_pkg::TS_EX1_DR : bsc_pkg::TS_SH_DR;
      bsc_pkg::TS_EX1_DR:
        nxt_state = tms ? bsc_pkg::TS_UPD_DR : bsc_pkg::TS_PAU_DR;
      bsc_pkg::TS_PAU_DR:
        nxt_state = tms ? bsc_pkg::TS_EX2_DR : bsc_pkg::TS_PAU_DR;
      bsc_pkg::TS_EX2_DR:
        nxt_state = tms ? bsc_pkg::TS_UPD_DR : bsc_pkg::TS_SH_DR;
      bsc_pkg::TS_UPD_DR:
        nxt_state = tms ? bsc_pkg::TS_SEL_DR : bsc_pkg::TS_IDLE;
      bsc_pkg::TS_SEL_IR:
        nxt_state = tms ? bsc_pkg::TS_RESET : bsc_pkg::TS_CAP_IR;
      bsc_pkg::TS_CAP_IR:
        nxt_state = tms ? bsc_pkg::TS_EX1_IR : bsc_pkg::TS_SH_IR;
      bsc_pkg::TS_SH_IR:
        nxt_state = tms ? bsc_pkg::TS_EX1_IR : bsc_pkg::TS_SH_IR;
      bsc_pkg::TS_EX1_IR:
        nxt_state = tms ? bsc_pkg::TS_UPD_IR : bsc_pkg::TS_PAU_IR;
      bsc_pkg::TS_PAU_IR:
        nxt_state = tms ? bsc_pkg::TS_EX2_IR : bsc_pkg::TS_PAU_IR;
      bsc_pkg::TS_EX2_IR:
        nxt_state = tms ? bsc_pkg::TS_UPD_IR : bsc_pkg::TS_SH_IR;
      bsc_pkg::TS_UPD_IR:
        nxt_state = tms ? bsc_pkg::TS_SEL_DR : bsc_pkg::TS_IDLE;
      default:
        nxt_state = bsc_pkg::TS_RESET;
    endcase
  end

  // ==========================================================================
  // instruction register
  always_ff @(posedge link.tck) begin
    if (tap_rst) begin
      ir_shift_ff <= bsc_pkg::IR_CAPT;
    end else if (state_ff == bsc_pkg::TS_CAP_IR) begin
      ir_shift_ff <= bsc_pkg::IR_CAPT;
    end else if (state_ff == bsc_pkg::TS_SH_IR) begin
      ir_shift_ff <= {tdi, ir_shift_ff[bsc_pkg::IR_LEN-1:1]}; // RQ6
    end
  end

  always_ff @(posedge link.tck) begin
    if (tap_rst || state_ff == bsc_pkg::TS_RESET) begin
      ir_ff <= bsc_pkg::OP_BYPASS; // RQ10
    end else if (state_ff == bsc_pkg::TS_UPD_IR) begin
      ir_ff <= ir_shift_ff; // RQ6
    end
  end

  // every code other than extest and sample selects bypass
  assign sel_extest = ir_ff == bsc_pkg::OP_EXTEST; // RQ10
  assign sel_sample = ir_ff == bsc_pkg::OP_SAMPLE; // RQ10
  assign sel_bnd    = sel_extest || sel_sample;
  assign sel_byp    = !sel_bnd; // RQ10

  // ==========================================================================
  // bypass cell
  always_ff @(posedge link.tck) begin
    if (tap_rst) begin
      byp_ff <= 1'b0;
    end else if (sel_byp && state_ff == bsc_pkg::TS_CAP_DR) begin
      byp_ff <= 1'b0; // RQ11
    end else if (sel_byp && state_ff == bsc_pkg::TS_SH_DR) begin
      byp_ff <= tdi; // RQ5
    end
  end

  // ==========================================================================
  // boundary register, capture and shift stage
  always_ff @(posedge link.tck) begin
    if (tap_rst) begin
      bnd_shift_ff <= '0;
    end else if (sel_bnd && state_ff == bsc_pkg::TS_CAP_DR) begin
      bnd_shift_ff <= pin_sync_ff; // RQ3 RQ4
    end else if (sel_bnd && state_ff == bsc_pkg::TS_SH_DR) begin
      bnd_shift_ff <= {tdi, bnd_shift_ff[BND_LEN-1:1]}; // RQ7
    end
  end

  // update stage holds a preloaded pattern until extest drives it
  always_ff @(posedge link.tck) begin
    if (tap_rst) begin
      bnd_upd_ff <= '0;
    end else if (sel_bnd && state_ff == bsc_pkg::TS_UPD_DR) begin
      bnd_upd_ff <= bnd_shift_ff; // RQ3
    end
  end

  // ==========================================================================
  // tdo launched on the falling edge
  always_ff @(negedge link.tck) begin
    if (tap_rst) begin
      tdo_ff    <= 1'b1;
      tdo_oe_ff <= 1'b0;
    end else begin
      tdo_oe_ff <= state_ff == bsc_pkg::TS_SH_IR
                || state_ff == bsc_pkg::TS_SH_DR; // RQ1
      if (state_ff == bsc_pkg::TS_SH_IR) begin
        tdo_ff <= ir_shift_ff[0];
      end else if (state_ff == bsc_pkg::TS_SH_DR) begin
        tdo_ff <= sel_bnd ? bnd_shift_ff[0] : byp_ff; // RQ5
      end
    end
  end

  assign link.tdo_o  = tdo_ff;
  assign link.tdo_oe = tdo_oe_ff;

  // ==========================================================================
  // pins: core path unless extest, nothing driven before power is good
  assign pin_out = sel_extest ? bnd_upd_ff : core_out; // RQ3 RQ4
  assign pin_oe  = !power_ok   ? '0 // RQ9
                 : sel_extest ? '1 : core_oe; // RQ4

  assign scan_blocked = cfg_sync_ff;
  assign ir_active    = ir_ff;
endmodule : bsc_tap_dev

// ---- test/bsc_tap_sva.sv ----
// concurrent checks on the link wires between the two tap ends
`timescale 1ns/1ps
module bsc_tap_sva (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic tck,
  input wire logic tms_o,
  input wire logic tms_oe,
  input wire logic tdi_o,
  input wire logic tdi_oe,
  input wire logic tdo_o,
  input wire logic tdo_oe,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo
);
  // ==========================================================================
  // link rules
  default clocking dflt_cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  chk_tms_pullup: assert property (!tms_oe |-> tms)
    else $error("tms not pulled high when released");
  chk_tdi_pullup: assert property (!tdi_oe |-> tdi)
    else $error("tdi not pulled high when released");
  chk_tdo_pullup: assert property (!tdo_oe |-> tdo)
    else $error("tdo not pulled high when released");
  chk_tck_idle_low: assert property (!tms_oe |-> !tck)
    else $error("tck runs outside a frame");
  chk_tck_high_time: assert property ($rose(tck) |-> tck[*4] ##1 !tck)
    else $error("tck high phase has wrong length");
  chk_tck_low_time: assert property ($fell(tck) |-> !tck[*4])
    else $error("tck low phase too short");
  chk_tms_tdi_hold: assert property (
      tck |-> $stable(tms_o) && $stable(tdi_o))
    else $error("tms or tdi moved while tck high");
  chk_tdo_on_fall: assert property ($changed(tdo_o) |-> !tck)
    else $error("tdo changed while tck high");
  chk_tdo_in_frame: assert property (tdo_oe |-> tms_oe)
    else $error("tdo driven outside a frame");
  chk_frame_start: assert property (
      $rose(tms_oe) |-> !tck ##[1:10] $rose(tck))
    else $error("no tck rise soon after frame start");
endmodule : bsc_tap_sva

// ---- test/bsc_tap_bench.sv ----
// self-checking bench of controller and device joined by the link
`timescale 1ns/1ps
module bsc_tap_bench;
  // ==========================================================================
  // signals
  localparam int BLEN = bsc_pkg::BND_LEN_SMALL;
  localparam int HALF = 4;
  localparam int LW   = $clog2(BLEN + 1);
  logic              ref_clk;
  logic              sys_rst;
  logic              cmd_valid;
  logic              cmd_ready;
  bsc_pkg::bsc_cmd_t cmd_op;
  logic [LW-1:0]     cmd_len;
  logic [BLEN-1:0]   cmd_data;
  logic              rsp_valid;
  logic [BLEN-1:0]   rsp_data;
  logic              config_busy;
  logic              power_ok;
  logic [BLEN-1:0]   pin_in;
  logic [BLEN-1:0]   core_out;
  logic [BLEN-1:0]   core_oe;
  logic [BLEN-1:0]   pin_out;
  logic [BLEN-1:0]   pin_oe;
  logic              scan_blocked;
  logic [2:0]        ir_active;
  logic [31:0]       lfsr_ff;
  logic [BLEN-1:0]   exp_q[$];
  logic              care_q[$];
  int                n_errors = 0;
  int                checks_done = 0;

  // ==========================================================================
  // ends, link and checker
  bsc_tap_if bsc_tap_if_i ();
  bsc_tap_ctl #(.BND_LEN(BLEN), .HALF_CYC(HALF)) bsc_tap_ctl_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .link(bsc_tap_if_i),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_len(cmd_len), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data));
  bsc_tap_dev #(.BND_LEN(BLEN)) bsc_tap_dev_i (
    .link(bsc_tap_if_i), .sys_rst(sys_rst), .config_busy(config_busy),
    .power_ok(power_ok), .pin_in(pin_in), .core_out(core_out),
    .core_oe(core_oe), .pin_out(pin_out), .pin_oe(pin_oe),
    .scan_blocked(scan_blocked), .ir_active(ir_active));
  bsc_tap_sva bsc_tap_sva_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .tck(bsc_tap_if_i.tck),
    .tms_o(bsc_tap_if_i.tms_o), .tms_oe(bsc_tap_if_i.tms_oe),
    .tdi_o(bsc_tap_if_i.tdi_o), .tdi_oe(bsc_tap_if_i.tdi_oe),
    .tdo_o(bsc_tap_if_i.tdo_o), .tdo_oe(bsc_tap_if_i.tdo_oe),
    .tms(bsc_tap_if_i.tms), .tdi(bsc_tap_if_i.tdi),
    .tdo(bsc_tap_if_i.tdo));

  initial begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ==========================================================================
  // helpers
  function automatic logic [BLEN-1:0] rnd();
    logic [BLEN-1:0] v;
    for (int i = 0; i < BLEN; i++) begin
      lfsr_ff = {lfsr_ff[30:0],
                 lfsr_ff[31] ^ lfsr_ff[21] ^ lfsr_ff[1] ^ lfsr_ff[0]};
      v[i] = lfsr_ff[0];
    end
    return v;
  endfunction : rnd

  task automatic cmp_rsp(input logic [BLEN-1:0] got,
                         input logic [BLEN-1:0] ex);
    checks_done++;
    if (got !== ex) begin
      n_errors++;
      $display("wrong value rsp at %0t: got %h exp %h", $time, got, ex);
    end
  endtask : cmp_rsp

  task automatic cmp_port(input logic [BLEN-1:0] got,
                          input logic [BLEN-1:0] ex);
    checks_done++;
    if (got !== ex) begin
      n_errors++;
      $display("wrong value port at %0t: got %h exp %h", $time, got, ex);
    end
  endtask : cmp_port

  task automatic scan(input bsc_pkg::bsc_cmd_t op, input int len,
                      input logic [BLEN-1:0] d, input logic care,
                      input logic [BLEN-1:0] ex);
    int n;
    exp_q.push_back(ex);
    care_q.push_back(care);
    @(posedge ref_clk);
    cmd_op    <= op;
    cmd_len   <= LW'(len);
    cmd_data  <= d;
    cmd_valid <= 1'h1;
    @(posedge ref_clk);
    cmd_valid <= 1'h0;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (rsp_valid !== 1'h1 && n < 6000);
    if (n >= 6000) begin
      n_errors++;
    end
  endtask : scan

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================================================
  // response monitor
  always @(negedge ref_clk) begin
    if (rsp_valid === 1'h1) begin
      if (exp_q.size() == 0) begin
        n_errors++;
      end else if (care_q.pop_front()) begin
        cmp_rsp(rsp_data, exp_q.pop_front());
      end else begin
        void'(exp_q.pop_front());
      end
    end
  end

  initial begin
    repeat (30000) @(posedge ref_clk);
    n_errors++;
    tally_and_finish();
  end

  // ==========================================================================
  // main sequence
  initial begin
    logic [BLEN-1:0] d;
    logic [BLEN-1:0] e;
    logic [BLEN-1:0] pv;
    lfsr_ff     = 32'h8894;
    sys_rst     = 1'h1;
    cmd_valid   = 1'h0;
    cmd_op      = bsc_pkg::CMD_RESET;
    cmd_len     = '0;
    cmd_data    = '0;
    config_busy = 1'h0;
    power_ok    = 1'h1;
    pin_in      = rnd();
    core_out    = rnd();
    core_oe     = rnd();
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'h0;
    scan(bsc_pkg::CMD_RESET, 6, '0, 1'h0, '0);
    cmp_port(BLEN'(ir_active), BLEN'(bsc_pkg::OP_BYPASS));
    cmp_port(BLEN'(cmd_ready), BLEN'(1'h1));
    d = rnd();
    scan(bsc_pkg::CMD_DR, 8, d, 1'h1, BLEN'({d[6:0], 1'h0}));
    cmp_port(pin_out, core_out);
    scan(bsc_pkg::CMD_IR, 3, BLEN'(bsc_pkg::OP_SAMPLE), 1'h1,
         BLEN'(bsc_pkg::IR_CAPT));
    cmp_port(BLEN'(ir_active), BLEN'(bsc_pkg::OP_SAMPLE));
    d = rnd();
    scan(bsc_pkg::CMD_DR, BLEN, d, 1'h1, pin_in);
    cmp_port(pin_out, core_out);
    cmp_port(pin_oe, core_oe);
    scan(bsc_pkg::CMD_IR, 3, BLEN'(bsc_pkg::OP_EXTEST), 1'h1,
         BLEN'(bsc_pkg::IR_CAPT));
    cmp_port(pin_out, d);
    cmp_port(pin_oe, {BLEN{1'h1}});
    pv = rnd();
    e  = rnd();
    @(posedge ref_clk);
    pin_in   <= pv;
    core_out <= rnd();
    scan(bsc_pkg::CMD_DR, BLEN, e, 1'h1, pv);
    cmp_port(pin_out, e);
    @(posedge ref_clk);
    power_ok <= 1'h0;
    @(posedge ref_clk);
    #1;
    cmp_port(pin_oe, '0);
    @(posedge ref_clk);
    power_ok <= 1'h1;
    scan(bsc_pkg::CMD_RESET, 6, '0, 1'h0, '0);
    cmp_port(BLEN'(ir_active), BLEN'(bsc_pkg::OP_BYPASS));
    cmp_port(pin_out, core_out);
    for (int k = 1; k < 8; k++) begin
      if (k != 5) begin
        scan(bsc_pkg::CMD_IR, 3, BLEN'(k), 1'h1,
             BLEN'(bsc_pkg::IR_CAPT));
        d = rnd();
        scan(bsc_pkg::CMD_DR, 8, d, 1'h1, BLEN'({d[6:0], 1'h0}));
      end
    end
    @(posedge ref_clk);
    config_busy <= 1'h1;
    scan(bsc_pkg::CMD_IR, 3, BLEN'(bsc_pkg::OP_EXTEST), 1'h1,
         BLEN'({bsc_pkg::IR_LEN{1'h1}}));
    cmp_port(BLEN'(scan_blocked), BLEN'(1'h1));
    cmp_port(BLEN'(ir_active), BLEN'(bsc_pkg::OP_BYPASS));
    @(posedge ref_clk);
    config_busy <= 1'h0;
    scan(bsc_pkg::CMD_RESET, 6, '0, 1'h0, '0);
    cmp_port(BLEN'(scan_blocked), '0);
    scan(bsc_pkg::CMD_IR, 3, BLEN'(bsc_pkg::OP_SAMPLE), 1'h1,
         BLEN'(bsc_pkg::IR_CAPT));
    tally_and_finish();
  end
endmodule : bsc_tap_bench
